// ===== rtl/modcfg_pkg.sv
/*
 * Package for the modulator configuration and lock detect block:
 * register addresses, field layouts, reset values, seed table and lock counts.
 * Assumes a register port with 5-bit word addresses and 24-bit data.
 */
`default_nettype none

package modcfg_pkg;

	// ----------------------------------------------------------------
	// Register addresses
	// ----------------------------------------------------------------
	localparam logic [4:0] ADDR_INT_FREQ = 5'h03;
	localparam logic [4:0] ADDR_FRAC_FREQ = 5'h04;
	localparam logic [4:0] ADDR_VCO_PORT = 5'h05;
	localparam logic [4:0] ADDR_MOD_CFG = 5'h06;
	localparam logic [4:0] ADDR_LOCK_CTRL = 5'h07;
	localparam logic [4:0] ADDR_LOCK_STATUS = 5'h12;

	// ----------------------------------------------------------------
	// Field layouts and reset values
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0] rsv_23_22;
		logic auto_clk_cfg;
		logic [8:0] rsv_20_12;
		logic sigma_delta_core_on;
		logic [2:0] init_bits;
		logic modulator_output_skip;
		logic [4:0] rsv_6_2;
		logic [1:0] seed_choice;
	} mod_cfg_t;

	typedef struct packed {
		logic [9:0] rsv_23_14;
		logic relock_on_loss;
		logic rsv_12;
		logic [1:0] lock_timer_speed;
		logic [2:0] lock_window_length;
		logic lock_window_source;
		logic [1:0] rsv_5_4;
		logic lock_detector_on;
		logic [2:0] lock_count_threshold;
	} lock_cfg_t;

	localparam logic [23:0] MOD_CFG_RESET = 24'h200b4a;
	localparam logic [23:0] LOCK_CTRL_RESET = 24'h00014d;

	// VCO port write that arms calibration: id and address bits all zero
	localparam logic [6:0] VCO_FINAL_MASK = 7'h7f;

	// ----------------------------------------------------------------
	// Seed table, indexed by the seed choice
	// ----------------------------------------------------------------
	localparam logic [3:0][23:0] SEED_TABLE = {24'h50f1cd, 24'hb29d08, 24'h000001, 24'h000000};
	localparam logic [1:0] SEED_RESET_CHOICE = 2'h2;

	// ----------------------------------------------------------------
	// Consecutive in-window counts needed to declare lock
	// ----------------------------------------------------------------
	localparam logic [7:0][16:0] LOCK_COUNTS = {17'h0ffff, 17'h02000, 17'h00800, 17'h00200,
		17'h00100, 17'h00060, 17'h00020, 17'h00005};

	// Window timer: prescaler and half-tick counter widths
	localparam int PRESC_W = 3;
	localparam int ELAPSED_W = 8;
	localparam logic [7:0] ELAPSED_MAX = 8'hff;

	// Read-back packing of the lock status word
	typedef struct packed {
		logic [21:0] rsv;
		logic relock_spent;
		logic locked;
	} lock_status_t;

	// Lock detector states
	typedef enum logic [1:0] {
		LD_OFF,
		LD_SEARCH,
		LD_LOCKED
	} lock_state_t;

endpackage

`default_nettype wire

// ===== rtl/modulator_config_lock_detect.sv
/*
 * Modulator configuration and digital lock detector.
 * Holds the modulator configuration and lock detect control registers,
 * loads the modulator seed on a frequency change, starts calibration and
 * watches consecutive phase comparisons for lock.
 * Assumes the serial port engine, the phase detector and the one-shot all
 * run on sys_clk and hand over single-cycle pulses.
 */
// Behaviour
// - Seed choice is stored; loaded into modulator on frequency change if bit 8 set.
// - Seed choice 0,1,2,3 gives zero, LSB, 0xB29D08, 0x50F1CD.
// - Skip bit ignores modulator output; modulator clocked while core enable set.
// - Core enable picks integer or fractional write as calibration trigger.
// - Core enable clear disables fractional core; set enables it.
// - Lock after programmed consecutive in-window counts: 5 up to 65,535.
// - Lock detector runs only while enabled; enable resets to one.
// - Window source: one selects digital timer, zero the analog one-shot.
// - Digital window: half cycle, then 1 to 64 cycles by code.
// - Timer speed field sets digital timer rate, 00 fastest, 11 slowest.
// - With relock set, one automatic relock attempt when lock detection fails.
// - After final VCO port write with zero bits, frequency write starts calibration.
`default_nettype none

module modulator_config_lock_detect (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [4:0] reg_addr,
	input wire logic [23:0] reg_wdata,
	output logic [23:0] reg_rdata,
	input wire logic cmp_open,
	input wire logic cmp_close,
	input wire logic analog_in_window,
	output logic [23:0] mod_seed,
	output logic mod_seed_load,
	output logic mod_clock_run,
	output logic mod_output_used,
	output logic autocal_start,
	output logic analog_oneshot_en,
	output logic locked
);

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	modcfg_pkg::mod_cfg_t mod_cfg_q;
	modcfg_pkg::lock_cfg_t lock_cfg_q;
	logic [23:0] rdata_q;
	logic [23:0] rdata_d;
	logic armed_q;
	logic [23:0] seed_q;
	logic seed_load_q;
	logic autocal_q;
	logic relock_spent_q;
	logic [modcfg_pkg::PRESC_W-1:0] presc_q;
	logic [modcfg_pkg::ELAPSED_W-1:0] elapsed_q;
	logic [16:0] tally_q;
	modcfg_pkg::lock_state_t state_q;
	modcfg_pkg::lock_state_t state_d;

	// Address decode of the write port
	wire wr_mod = reg_wr && (reg_addr == modcfg_pkg::ADDR_MOD_CFG);
	wire wr_lock = reg_wr && (reg_addr == modcfg_pkg::ADDR_LOCK_CTRL);
	wire wr_vco = reg_wr && (reg_addr == modcfg_pkg::ADDR_VCO_PORT);
	wire wr_int = reg_wr && (reg_addr == modcfg_pkg::ADDR_INT_FREQ);
	wire wr_frac = reg_wr && (reg_addr == modcfg_pkg::ADDR_FRAC_FREQ);
	wire vco_final = (reg_wdata[6:0] & modcfg_pkg::VCO_FINAL_MASK) == 7'h00;

	// Storing every bit keeps read-back exact; host owns skip and init bits
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			mod_cfg_q <= modcfg_pkg::MOD_CFG_RESET;
			lock_cfg_q <= modcfg_pkg::LOCK_CTRL_RESET;
		end else begin
			if (wr_mod) begin
				mod_cfg_q <= reg_wdata;
			end
			if (wr_lock) begin
				lock_cfg_q <= reg_wdata;
			end
		end
	end

	// Read mux; unknown addresses return zero
	wire modcfg_pkg::lock_status_t status_word = '{rsv: 22'h000000,
		relock_spent: relock_spent_q, locked: (state_q == modcfg_pkg::LD_LOCKED)};
	always_comb begin
		rdata_d = 24'h000000;
		case (reg_addr)
			modcfg_pkg::ADDR_MOD_CFG: rdata_d = mod_cfg_q;
			modcfg_pkg::ADDR_LOCK_CTRL: rdata_d = lock_cfg_q;
			modcfg_pkg::ADDR_LOCK_STATUS: rdata_d = status_word;
			default: rdata_d = 24'h000000;
		endcase
	end

	// Read data is captured one cycle after the read strobe
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rdata_q <= 24'h000000;
		end else if (reg_rd) begin
			rdata_q <= rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// Calibration trigger and seed load
	// ----------------------------------------------------------------
	// trigger follows core enable
	wire freq_write = mod_cfg_q.sigma_delta_core_on ? wr_frac : wr_int;
	wire freq_change = freq_write && armed_q;
	// seed loads only with bit 8
	wire seed_load = freq_change && mod_cfg_q.init_bits[0];
	wire [23:0] seed_value = modcfg_pkg::SEED_TABLE[mod_cfg_q.seed_choice];

	// Arming survives calibrations so a hop needs only the frequency write
	// arm on final port write
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			armed_q <= 1'b0;
		end else if (wr_vco) begin
			armed_q <= vco_final;
		end
	end

	// Seed register and load strobe
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			seed_q <= modcfg_pkg::SEED_TABLE[modcfg_pkg::SEED_RESET_CHOICE];
			seed_load_q <= 1'b0;
		end else begin
			seed_load_q <= seed_load;
			if (seed_load) begin
				seed_q <= seed_value;
			end
		end
	end

	// ----------------------------------------------------------------
	// Digital window timer
	// ----------------------------------------------------------------
	// prescale by two to the speed code
	wire [modcfg_pkg::PRESC_W-1:0] presc_mask =
		(modcfg_pkg::PRESC_W)'((4'h1 << lock_cfg_q.lock_timer_speed) - 4'h1);
	wire half_tick = (presc_q & presc_mask) == presc_mask;
	// window in half ticks is two to the length code
	wire [modcfg_pkg::ELAPSED_W-1:0] window_limit =
		(modcfg_pkg::ELAPSED_W)'(8'h01 << lock_cfg_q.lock_window_length);

	// Free-running prescaler; no reset of phase on open, so up to one tick of skew
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			presc_q <= '0;
		end else begin
			presc_q <= presc_q + 3'h1;
		end
	end

	// Half ticks since the opening edge, saturating
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			elapsed_q <= '0;
		end else if (cmp_open) begin
			elapsed_q <= '0;
		end else if (half_tick && elapsed_q != modcfg_pkg::ELAPSED_MAX) begin
			elapsed_q <= elapsed_q + 8'h01;
		end
	end

	wire in_window = lock_cfg_q.lock_window_source ? (elapsed_q < window_limit)
		: analog_in_window;
	wire cmp_good = cmp_close && in_window;
	wire cmp_bad = cmp_close && !in_window;
	wire [16:0] count_target = modcfg_pkg::LOCK_COUNTS[lock_cfg_q.lock_count_threshold];
	wire tally_full = (tally_q + 17'h00001) >= count_target;

	// ----------------------------------------------------------------
	// Lock detector
	// ----------------------------------------------------------------
	// Next lock state
	always_comb begin
		state_d = state_q;
		case (state_q)
			modcfg_pkg::LD_OFF: begin
				if (lock_cfg_q.lock_detector_on) begin
					state_d = modcfg_pkg::LD_SEARCH;
				end
			end
			modcfg_pkg::LD_SEARCH: begin
				if (cmp_good && tally_full) begin
					state_d = modcfg_pkg::LD_LOCKED;
				end
			end
			modcfg_pkg::LD_LOCKED: begin
				if (cmp_bad) begin
					state_d = modcfg_pkg::LD_SEARCH;
				end
			end
			default: state_d = modcfg_pkg::LD_OFF;
		endcase
		if (!lock_cfg_q.lock_detector_on) begin
			state_d = modcfg_pkg::LD_OFF;
		end
	end

	// State and consecutive tally
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q <= modcfg_pkg::LD_OFF;
			tally_q <= 17'h00000;
		end else begin
			state_q <= state_d;
			if (state_d == modcfg_pkg::LD_OFF || cmp_bad) begin
				tally_q <= 17'h00000;
			end else if (cmp_good && !tally_full) begin
				tally_q <= tally_q + 17'h00001;
			end
		end
	end

	// ----------------------------------------------------------------
	// Automatic relock
	// ----------------------------------------------------------------
	// single relock on loss
	wire lock_lost = (state_q == modcfg_pkg::LD_LOCKED) && cmp_bad;
	wire relock = lock_lost && lock_cfg_q.relock_on_loss && !relock_spent_q;

	// A host-started calibration rearms the one attempt; set wins over rearm
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			relock_spent_q <= 1'b0;
			autocal_q <= 1'b0;
		end else begin
			autocal_q <= freq_change || relock;
			if (relock) begin
				relock_spent_q <= 1'b1;
			end else if (freq_change) begin
				relock_spent_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign reg_rdata = rdata_q;
	assign mod_seed = seed_q;
	assign mod_seed_load = seed_load_q;
	assign mod_clock_run = mod_cfg_q.sigma_delta_core_on;
	assign mod_output_used = !mod_cfg_q.modulator_output_skip;
	assign autocal_start = autocal_q;
	assign analog_oneshot_en = lock_cfg_q.lock_detector_on && !lock_cfg_q.lock_window_source;
	assign locked = (state_q == modcfg_pkg::LD_LOCKED);

endmodule

`default_nettype wire

// ===== verification/modcfg_props.sv
/* Checker for the modulator config and lock detect block.
   Sees only the top ports; bound to every instance of the top. */
`default_nettype none
module modcfg_props (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic reg_wr,
	input wire logic [4:0] reg_addr,
	input wire logic [23:0] reg_wdata,
	input wire logic cmp_close,
	input wire logic analog_in_window,
	input wire logic [23:0] mod_seed,
	input wire logic mod_seed_load,
	input wire logic mod_clock_run,
	input wire logic mod_output_used,
	input wire logic autocal_start,
	input wire logic analog_oneshot_en,
	input wire logic locked
);
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------------------------------
	// Port relations
	// ----------------------------------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// Config register writes
	wire w6 = reg_wr && reg_addr == 5'h06;
	wire w7 = reg_wr && reg_addr == 5'h07;
	a_core_run_follows: assert property (w6 |=> mod_clock_run == $past(reg_wdata[11]))
		else $error("core run level wrong");
	a_skip_drops_output: assert property (w6 |=> mod_output_used == !$past(reg_wdata[7]))
		else $error("output use level wrong");
	a_oneshot_from_cfg: assert property (w7 |=> analog_oneshot_en ==
		($past(reg_wdata[3]) && !$past(reg_wdata[6]))) else $error("one-shot enable wrong");
	a_seed_with_cal: assert property (mod_seed_load |-> autocal_start)
		else $error("seed load without calibration");
	a_seed_in_table: assert property (mod_seed_load |-> mod_seed inside {24'h000000,
		24'h000001, 24'hb29d08, 24'h50f1cd}) else $error("seed not in table");
	a_cal_has_cause: assert property (autocal_start |-> $fell(locked) ||
		$past(reg_wr && (reg_addr == 5'h03 || reg_addr == 5'h04))) else $error("stray cal");
	a_miss_drops_lock: assert property (locked && cmp_close && analog_oneshot_en &&
		!analog_in_window |=> !locked) else $error("lock kept after miss");
	a_off_clears_lock: assert property (w7 && !reg_wdata[3] |=> ##1 !locked)
		else $error("lock kept while disabled");
	a_lock_after_close: assert property ($rose(locked) |-> $past(cmp_close))
		else $error("lock without comparison");
	// Main scenarios reached
	c_seed: cover property (mod_seed_load);
	c_lock: cover property ($rose(locked));
	c_relock: cover property ($fell(locked) && autocal_start);
endmodule
bind modulator_config_lock_detect modcfg_props chk (.sys_clk, .rst, .reg_wr, .reg_addr,
	.reg_wdata, .cmp_close, .analog_in_window, .mod_seed, .mod_seed_load, .mod_clock_run,
	.mod_output_used, .autocal_start, .analog_oneshot_en, .locked);
`default_nettype wire

// ===== verification/reg_host.sv
/* Host model of the serial register port: write and read tasks.
   Assumes sys_clk runs and reset is released before the first call. */
`default_nettype none
module reg_host (
	input wire logic sys_clk,
	input wire logic [23:0] reg_rdata,
	output logic reg_wr,
	output logic reg_rd,
	output logic [4:0] reg_addr,
	output logic [23:0] reg_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 5'h00;
		reg_wdata = 24'h000000;
	end
	// Released data bus shows the inverse, never a stale copy
	task automatic wr(input logic [4:0] a, input logic [23:0] d);
		@(posedge sys_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~d;
	endtask
	task automatic rd(input logic [4:0] a, output logic [23:0] d);
		@(posedge sys_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
endmodule
`default_nettype wire

// ===== verification/tb_modulator_config_lock_detect.sv
/* Testbench for the modulator config and lock detect block.
   Host model drives the registers; comparison pulses come from here. */
`default_nettype none
module tb_modulator_config_lock_detect;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic cmp_open = 1'b0;
	logic cmp_close = 1'b0;
	logic analog_in_window = 1'b0;
	logic reg_wr, reg_rd, mod_seed_load, mod_clock_run, mod_output_used;
	logic autocal_start, analog_oneshot_en, locked;
	logic [4:0] reg_addr;
	logic [23:0] reg_wdata, reg_rdata, mod_seed, rv;
	int errors = 0;
	int samples_checked = 0;
	always #50 sys_clk = ~sys_clk;
	modulator_config_lock_detect dut (.sys_clk, .rst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
		.reg_rdata, .cmp_open, .cmp_close, .analog_in_window, .mod_seed, .mod_seed_load,
		.mod_clock_run, .mod_output_used, .autocal_start, .analog_oneshot_en, .locked);
	reg_host host (.sys_clk, .reg_rdata, .reg_wr, .reg_rd, .reg_addr, .reg_wdata);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input string n, input logic [23:0] got, input logic [23:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("unexpected %s: expected %h, seen %h", n, exp, got);
		end
	endtask
	task automatic stop_test();
		$display("errors %0d, checks %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// One comparison; analog verdict inverted once the close pulse ends
	task automatic cmp(input int gap, input logic win);
		@(posedge sys_clk);
		cmp_open <= 1'b1;
		@(posedge sys_clk);
		cmp_open <= 1'b0;
		repeat (gap) @(posedge sys_clk);
		cmp_close <= 1'b1;
		analog_in_window <= win;
		@(posedge sys_clk);
		cmp_close <= 1'b0;
		analog_in_window <= ~win;
		#1;
	endtask
	task automatic lockup(input int gap);
		repeat (4) cmp(gap, 1'b1);
		chk("lock", locked, 0);
		cmp(gap, 1'b1);
		chk("lock", locked, 1);
	endtask
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset();
		host.rd(5'h06, rv);
		chk("cfg6", rv, 24'h200b4a);
		host.rd(5'h07, rv);
		chk("cfg7", rv, 24'h00014d);
		host.rd(5'h1f, rv);
		chk("none", rv, 0);
		chk("seed", mod_seed, 24'hb29d08);
		chk("shot", analog_oneshot_en, 0);
	endtask
	// Every seed choice, then the load gate cleared
	task automatic t_seed();
		logic [23:0] tbl [4] = '{24'h000000, 24'h000001, 24'hb29d08, 24'h50f1cd};
		host.wr(5'h05, 24'h000000);
		for (int k = 0; k < 4; k++) begin
			host.wr(5'h06, 24'h200f48 | 24'(k));
			host.wr(5'h04, 24'h123456);
			#1 chk("cal", autocal_start, 1);
			chk("load", mod_seed_load, 1);
			chk("seed", mod_seed, tbl[k]);
		end
		host.wr(5'h06, 24'h200e49);
		host.wr(5'h04, 24'h000001);
		#1 chk("load", mod_seed_load, 0);
		chk("seed", mod_seed, tbl[3]);
	endtask
	// Integer mode: trigger moves to the integer register, then disarm
	task automatic t_core();
		host.wr(5'h06, 24'h2007c8);
		#1 chk("run", mod_clock_run, 0);
		chk("used", mod_output_used, 0);
		host.wr(5'h04, 24'h000001);
		#1 chk("cal", autocal_start, 0);
		host.wr(5'h03, 24'h000020);
		#1 chk("cal", autocal_start, 1);
		chk("load", mod_seed_load, 1);
		chk("seed", mod_seed, 24'h000000);
		host.wr(5'h05, 24'h000009);
		host.wr(5'h03, 24'h000020);
		#1 chk("cal", autocal_start, 0);
		host.rd(5'h06, rv);
		chk("cfg6", rv, 24'h2007c8);
	endtask
	// Digital window: late close misses, slow timer stretches the window
	task automatic t_lock();
		host.wr(5'h07, 24'h000148);
		lockup(1);
		host.rd(5'h12, rv);
		chk("stat", rv, 1);
		cmp(8, 1'b1);
		chk("lock", locked, 0);
		chk("cal", autocal_start, 0);
		host.wr(5'h07, 24'h000d48);
		lockup(8);
	endtask
	// Analog window with a single relock attempt
	task automatic t_relock();
		host.wr(5'h07, 24'h000008);
		#1 chk("shot", analog_oneshot_en, 1);
		cmp(8, 1'b0);
		host.wr(5'h07, 24'h002008);
		lockup(8);
		cmp(0, 1'b0);
		chk("cal", autocal_start, 1);
		lockup(0);
		cmp(0, 1'b0);
		chk("cal", autocal_start, 0);
		host.rd(5'h12, rv);
		chk("stat", rv, 2);
	endtask
	// Disabled detector drops lock and ignores comparisons
	task automatic t_disable();
		lockup(0);
		host.wr(5'h07, 24'h002000);
		repeat (5) cmp(0, 1'b1);
		chk("lock", locked, 0);
		host.rd(5'h12, rv);
		chk("stat", rv, 2);
	endtask
	// Half-cycle window and the 32-count threshold
	task automatic t_window();
		host.wr(5'h07, 24'h000049);
		repeat (31) cmp(0, 1'b1);
		chk("lock", locked, 0);
		cmp(0, 1'b1);
		chk("lock", locked, 1);
		cmp(1, 1'b1);
		chk("lock", locked, 0);
	endtask
	initial begin
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset();
		t_seed();
		t_core();
		t_lock();
		t_relock();
		t_disable();
		t_window();
		stop_test();
	end
endmodule
`default_nettype wire
